//--- core/i2cm_pkg.sv
// Contract
// - Sixteen-bit bus clock prescale, read/write, reset to zero, sets bus clock rate.
// - Prescale low byte at the lower address, high byte at the next.
// - Eight-bit transmit byte, read/write, reset zero, sent on a write command.
// - Eight-bit receive byte, reset zero, captures the byte read from the slave.
// - Command bit 7 makes a start or repeated start, then clears itself.
// - Command bit 6 makes a stop condition, then clears itself.
// - Command bit 5 reads a byte, answering ACK or NACK per bit 3.
// - Command bit 4 sends the transmit byte, then clears itself.
// - Start, stop, read, write and acknowledge bits always read as zero.
// - Status bit 7 holds slave acknowledge: zero acknowledged, one not acknowledged.
// - Status bit 6 goes high once a start is seen on the bus.
// - Status bit 6 goes low once a stop is seen on the bus.
// - Status bit 1 reads one while the master moves a byte.
// - Status bit 1 reads zero once the byte transfer is finished.
// - Status bit 0 goes high when arbitration is lost.
// - A stop this master did not ask for counts as lost arbitration; the code flags it only while this master holds the bus after its own start.
// - Releasing data high while another master holds it low loses arbitration; the code checks this only on the eight data bits of a write command.
package i2cm_pkg;
	localparam int          ADDR_W          = 10;
	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_PRESCALE_LO = 8'hE5;
	localparam logic [7:0]  IDX_PRESCALE_HI = 8'hE6;
	localparam logic [7:0]  IDX_TRANSMIT    = 8'hE7;
	localparam logic [7:0]  IDX_RECEIVE     = 8'hE8;
	localparam logic [7:0]  IDX_COMMAND     = 8'hE9;
	localparam logic [7:0]  IDX_STATUS      = 8'hEA;
	localparam logic [7:0]  IDX_IRQ_STATUS  = 8'hEB;
	localparam logic [7:0]  IDX_IRQ_MASK    = 8'hEC;
	// Command bits
	localparam int          CMD_START       = 7;
	localparam int          CMD_STOP        = 6;
	localparam int          CMD_READ        = 5;
	localparam int          CMD_WRITE       = 4;
	localparam int          CMD_NACK        = 3;
	localparam int          CMD_FILTER      = 0;
	// Status bits
	localparam int          STAT_NOACK      = 7;
	localparam int          STAT_BUSY       = 6;
	localparam int          STAT_TIP        = 1;
	localparam int          STAT_ARBLOST    = 0;
	// Interrupt bits
	localparam int          IRQ_DONE        = 0;
	localparam int          IRQ_ARB         = 1;
	// Reset values and counts
	localparam logic [15:0] PRESCALE_RST    = 16'h0000;
	localparam logic [7:0]  BYTE_RST        = 8'h00;
	localparam logic [2:0]  FILT_CYCLES     = 3'h7;
	localparam logic [3:0]  ACK_BIT         = 4'h8;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	typedef enum logic [1:0] {
		FSM_IDLE  = 2'b00,
		FSM_START = 2'b01,
		FSM_BIT   = 2'b10,
		FSM_STOP  = 2'b11
	} i2cm_fsm_t;
endpackage

//--- core/i2cm_engine.sv
`timescale 1ns/1ps
module i2cm_engine (
	input  wire logic                       clock,
	input  wire logic                       sys_rst,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [i2cm_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	output logic [1:0]                      s_axi_bresp,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	input  wire logic [i2cm_pkg::ADDR_W-1:0] s_axi_araddr,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	input  wire logic                       scl_i,
	output logic                            scl_o,
	output logic                            scl_oe,
	input  wire logic                       sda_i,
	output logic                            sda_o,
	output logic                            sda_oe,
	output logic                            irq
);

	typedef struct packed {
		logic [1:0][2:0]     sync;
		logic [1:0]          line_f;
		logic [1:0][2:0]     fcnt;
		logic                filt_en;
		logic [15:0]         prescale;
		logic [7:0]          txd;
		logic [7:0]          rxd;
		logic                c_sta;
		logic                c_sto;
		logic                c_rd;
		logic                c_wr;
		logic                ack_sel;
		i2cm_pkg::i2cm_fsm_t st;
		logic [1:0]          phase;
		logic [15:0]         qcnt;
		logic [3:0]          bitcnt;
		logic [7:0]          shift;
		logic                scl_oe;
		logic                sda_oe;
		logic                drive_lvl;
		logic                held;
		logic                rx_ack;
		logic                busy;
		logic                al;
		logic                tip;
		logic [1:0]          ist;
		logic [1:0]          imask;
		logic                irq;
		logic                aw_ok;
		logic [7:0]          aw_idx;
		logic                w_ok;
		logic [7:0]          w_data;
		logic                w_en;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [7:0]          rdata;
		logic [1:0]          rresp;
		logic [7:0]          r_idx;
	} i2cm_regs_t;

	localparam i2cm_regs_t REG_RST = '0;

	i2cm_regs_t q;
	i2cm_regs_t n;

	function automatic logic bit_oe(input logic wr, input logic [3:0] k,
		input logic msb, input logic nack);
		if (k < i2cm_pkg::ACK_BIT)
			return wr & ~msb;
		return ~wr & ~nack;
	endfunction

	function automatic logic idx_mapped(input logic [7:0] idx);
		return idx >= i2cm_pkg::IDX_PRESCALE_LO && idx <= i2cm_pkg::IDX_IRQ_MASK;
	endfunction

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		logic       wr_fire;
		logic [7:0] wd;
		logic [7:0] rd;
		logic       adv;
		logic       start_det;
		logic       stop_det;
		logic       arb;
		logic       fin;
		logic       s;
		wr_fire   = 1'b0;
		wd        = 8'h00;
		rd        = 8'h00;
		adv       = 1'b0;
		start_det = 1'b0;
		stop_det  = 1'b0;
		arb       = 1'b0;
		fin       = 1'b0;
		s         = 1'b0;
		n         = q;

		// Pin inputs: three flops, change accepted once second and third agree (for eight cycles with the filter on)
		for (int i = 0; i < 2; i++) begin
			n.sync[i] = {q.sync[i][1:0], (i == 0) ? scl_i : sda_i};
			if (q.sync[i][2] == q.sync[i][1] && q.sync[i][2] != q.line_f[i]) begin
				if (!q.filt_en || q.fcnt[i] == i2cm_pkg::FILT_CYCLES) begin
					n.line_f[i] = q.sync[i][2];
					n.fcnt[i]   = 3'h0;
				end else begin
					n.fcnt[i] = q.fcnt[i] + 3'h1;
				end
			end else begin
				n.fcnt[i] = 3'h0;
			end
		end

		// Start and stop seen on the bus, whoever made them
		start_det = q.line_f[0] & n.line_f[0] & q.line_f[1] & ~n.line_f[1];
		stop_det  = q.line_f[0] & n.line_f[0] & ~q.line_f[1] & n.line_f[1];
		if (start_det)
			n.busy = 1'b1;
		if (stop_det)
			n.busy = 1'b0;

		// Register write taken; clears applied before hardware sets
		if (q.aw_ok && q.w_ok && !q.bvalid) begin
			wr_fire  = q.w_en;
			wd       = q.w_data;
			n.aw_ok  = 1'b0;
			n.w_ok   = 1'b0;
			n.bvalid = 1'b1;
			n.bresp  = idx_mapped(q.aw_idx) ? i2cm_pkg::RESP_OKAY : i2cm_pkg::RESP_SLVERR;
		end
		if (wr_fire && q.aw_idx == i2cm_pkg::IDX_IRQ_STATUS)
			n.ist = q.ist & ~wd[1:0];
		if (wr_fire && q.aw_idx == i2cm_pkg::IDX_COMMAND && wd[i2cm_pkg::CMD_START])
			n.al = 1'b0;

		////////////////////////////////////////////////////////////////////////
		// Bit engine; a quarter bit lasts prescale+1 clocks
		if (q.st != i2cm_pkg::FSM_IDLE) begin
			if (q.qcnt != 16'h0000) begin
				n.qcnt = q.qcnt - 16'h0001;
			end else if (!(q.phase == 2'h1 && !q.line_f[0])) begin
				// Slave may stretch the clock low; wait for it
				adv     = 1'b1;
				n.qcnt  = q.prescale;
				n.phase = q.phase + 2'h1;
			end
		end

		unique case (q.st)
			i2cm_pkg::FSM_IDLE: begin
				n.phase = 2'h0;
				n.qcnt  = q.prescale;
				if (q.c_sta) begin
					n.st     = i2cm_pkg::FSM_START;
					n.sda_oe = 1'b0;
				end else if (q.c_wr || q.c_rd) begin
					n.st     = i2cm_pkg::FSM_BIT;
					n.bitcnt = 4'h0;
					n.shift  = q.txd;
					n.sda_oe = bit_oe(q.c_wr, 4'h0, q.txd[7], q.ack_sel);
				end else if (q.c_sto) begin
					n.st     = i2cm_pkg::FSM_STOP;
					n.sda_oe = 1'b1;
				end
			end
			i2cm_pkg::FSM_START: if (adv) begin
				unique case (q.phase)
					2'h0: n.scl_oe = 1'b0;
					2'h1: n.sda_oe = 1'b1;
					2'h2: n.scl_oe = 1'b1;
					2'h3: begin
						n.c_sta = 1'b0;
						n.held  = 1'b1;
						fin     = 1'b1;
					end
				endcase
			end
			i2cm_pkg::FSM_STOP: if (adv) begin
				unique case (q.phase)
					2'h0: n.scl_oe = 1'b0;
					2'h1: n.sda_oe = 1'b0;
					2'h2: n.held = 1'b0;
					2'h3: begin
						n.c_sto = 1'b0;
						fin     = 1'b1;
					end
				endcase
			end
			i2cm_pkg::FSM_BIT: if (adv) begin
				unique case (q.phase)
					2'h0: n.scl_oe = 1'b0;
					2'h1: begin
						s = q.line_f[1];
						if (q.bitcnt < i2cm_pkg::ACK_BIT) begin
							n.shift = {q.shift[6:0], s};
							// Released high but another master holds it low
							if (q.c_wr && q.shift[7] && !s)
								arb = 1'b1;
						end else if (q.c_wr) begin
							n.rx_ack = s;
						end
					end
					2'h2: n.scl_oe = 1'b1;
					2'h3: begin
						if (q.bitcnt == i2cm_pkg::ACK_BIT) begin
							if (q.c_rd)
								n.rxd = q.shift;
							n.c_rd   = 1'b0;
							n.c_wr   = 1'b0;
							n.sda_oe = 1'b0;
							fin      = 1'b1;
						end else begin
							n.bitcnt = q.bitcnt + 4'h1;
							n.sda_oe = bit_oe(q.c_wr, q.bitcnt + 4'h1, q.shift[7], q.ack_sel);
						end
					end
				endcase
			end
		endcase

		if (fin)
			n.st = i2cm_pkg::FSM_IDLE;

		// A stop nobody here asked for while the bus was ours
		if (stop_det && q.held && q.st != i2cm_pkg::FSM_STOP)
			arb = 1'b1;

		if (arb) begin
			n.st     = i2cm_pkg::FSM_IDLE;
			n.c_sta  = 1'b0;
			n.c_sto  = 1'b0;
			n.c_rd   = 1'b0;
			n.c_wr   = 1'b0;
			n.scl_oe = 1'b0;
			n.sda_oe = 1'b0;
			n.held   = 1'b0;
			n.al     = 1'b1;
		end

		if (fin)
			n.ist[i2cm_pkg::IRQ_DONE] = 1'b1;
		if (arb)
			n.ist[i2cm_pkg::IRQ_ARB] = 1'b1;

		////////////////////////////////////////////////////////////////////////
		// Register writes that set after the engine, so a new command wins
		if (wr_fire) begin
			unique case (q.aw_idx)
				i2cm_pkg::IDX_PRESCALE_LO: n.prescale[7:0]  = wd;
				i2cm_pkg::IDX_PRESCALE_HI: n.prescale[15:8] = wd;
				i2cm_pkg::IDX_TRANSMIT:    n.txd            = wd;
				i2cm_pkg::IDX_RECEIVE:     n.rxd            = wd;
				i2cm_pkg::IDX_COMMAND: begin
					n.c_sta   = n.c_sta | wd[i2cm_pkg::CMD_START];
					n.c_sto   = n.c_sto | wd[i2cm_pkg::CMD_STOP];
					n.c_rd    = n.c_rd | wd[i2cm_pkg::CMD_READ];
					n.c_wr    = n.c_wr | wd[i2cm_pkg::CMD_WRITE];
					n.ack_sel = wd[i2cm_pkg::CMD_NACK];
					n.filt_en = wd[i2cm_pkg::CMD_FILTER];
				end
				i2cm_pkg::IDX_IRQ_MASK:    n.imask          = wd[1:0];
				default: ;
			endcase
		end

		// Busy while anything is pending or moving
		n.tip = n.c_sta | n.c_sto | n.c_rd | n.c_wr | (n.st != i2cm_pkg::FSM_IDLE);
		n.irq = |(n.ist & n.imask);
		n.drive_lvl = 1'b0;

		////////////////////////////////////////////////////////////////////////
		// AXI4-Lite handshakes
		if (s_axi_awvalid && q.awready) begin
			n.aw_ok  = 1'b1;
			n.aw_idx = s_axi_awaddr[i2cm_pkg::ADDR_W-1:2];
		end
		if (s_axi_wvalid && q.wready) begin
			n.w_ok   = 1'b1;
			n.w_data = s_axi_wdata[7:0];
			n.w_en   = s_axi_wstrb[0];
		end
		if (q.bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		n.awready = ~n.aw_ok & ~n.bvalid;
		n.wready  = ~n.w_ok & ~n.bvalid;

		unique case (s_axi_araddr[i2cm_pkg::ADDR_W-1:2])
			i2cm_pkg::IDX_PRESCALE_LO: rd = q.prescale[7:0];
			i2cm_pkg::IDX_PRESCALE_HI: rd = q.prescale[15:8];
			i2cm_pkg::IDX_TRANSMIT:    rd = q.txd;
			i2cm_pkg::IDX_RECEIVE:     rd = q.rxd;
			// Command strobes never read back
			i2cm_pkg::IDX_COMMAND:     rd = {7'h00, q.filt_en};
			i2cm_pkg::IDX_STATUS:      rd = {q.rx_ack, q.busy, 4'h0, q.tip, q.al};
			i2cm_pkg::IDX_IRQ_STATUS:  rd = {6'h00, q.ist};
			i2cm_pkg::IDX_IRQ_MASK:    rd = {6'h00, q.imask};
			default:                   rd = 8'h00;
		endcase
		if (s_axi_arvalid && q.arready) begin
			n.rvalid = 1'b1;
			n.rdata  = rd;
			n.r_idx  = s_axi_araddr[i2cm_pkg::ADDR_W-1:2];
			n.rresp  = idx_mapped(n.r_idx) ? i2cm_pkg::RESP_OKAY : i2cm_pkg::RESP_SLVERR;
		end else if (q.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		n.arready = ~n.rvalid;
	end

	always_ff @(posedge clock) begin
		if (sys_rst)
			q <= REG_RST;
		else
			q <= n;
	end

	////////////////////////////////////////////////////////////////////////////

	assign s_axi_awready = q.awready;
	assign s_axi_wready  = q.wready;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = {24'h000000, q.rdata};
	assign s_axi_rresp   = q.rresp;
	assign scl_o         = q.drive_lvl;
	assign sda_o         = q.drive_lvl;
	assign scl_oe        = q.scl_oe;
	assign sda_oe        = q.sda_oe;
	assign irq           = q.irq;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	chk_prescale_reset: assert property (disable iff (1'b0)
		$past(sys_rst) |-> q.prescale == i2cm_pkg::PRESCALE_RST)
		else $error("prescale not zero after reset");

	chk_cmd_reads_zero: assert property (
		$rose(q.rvalid) && q.r_idx == i2cm_pkg::IDX_COMMAND |-> q.rdata[7:1] == 7'h00)
		else $error("command strobe bits read back nonzero");

	chk_start_busy: assert property (
		$rose(q.line_f[1] == 1'b0) && q.line_f[0] && $past(q.line_f[0]) |-> q.busy)
		else $error("start seen but bus not busy");

	chk_stop_idle: assert property (
		$rose(q.line_f[1]) && q.line_f[0] && $past(q.line_f[0]) |-> !q.busy)
		else $error("stop seen but bus still busy");

	chk_tip_shift: assert property (q.st == i2cm_pkg::FSM_BIT |-> q.tip)
		else $error("byte moving without transfer in progress");

	chk_tip_done: assert property (
		q.st == i2cm_pkg::FSM_IDLE && !(q.c_sta | q.c_sto | q.c_rd | q.c_wr)
		&& !(q.aw_ok && q.w_ok) |=> !q.tip)
		else $error("transfer in progress with nothing to do");

	chk_arb_lost: assert property (
		q.st == i2cm_pkg::FSM_BIT && q.phase == 2'h1 && q.qcnt == 16'h0000 && q.line_f[0]
		&& q.c_wr && q.bitcnt < i2cm_pkg::ACK_BIT && q.shift[7] && !q.line_f[1]
		|=> q.al && !q.sda_oe && !q.scl_oe && q.st == i2cm_pkg::FSM_IDLE)
		else $error("data mismatch did not raise arbitration loss");

	chk_open_drain: assert property (
		!scl_o && !sda_o)
		else $error("line driven high");

	chk_wr_clears: assert property (
		q.st == i2cm_pkg::FSM_BIT && q.c_wr && q.bitcnt == i2cm_pkg::ACK_BIT && q.phase == 2'h3
		&& q.qcnt == 16'h0000 && !(q.aw_ok && q.w_ok) && !(q.c_sta | q.c_sto)
		|=> !q.c_wr && !q.tip)
		else $error("write command did not clear itself");

	// Both ways, so a cleared event must also drop the pin
	chk_irq_level: assert property (irq == (|(q.ist & q.imask)))
		else $error("interrupt pin disagrees with unmasked events");

endmodule

//--- tb/i2cm_slave_model.sv
`timescale 1ns/1ps
module i2cm_slave_model (
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       ack_en,
	input  wire logic       rd_mode,
	input  wire logic       clash,
	input  wire logic [7:0] rd_byte,
	output logic            sda_pull,
	output logic [7:0]      got_byte,
	output logic            got_ack
);
	int         bit_cnt;
	logic       active;
	logic [7:0] shift;
	initial begin
		sda_pull = 1'b0;
		got_byte = 8'h00;
		got_ack  = 1'b0;
		bit_cnt  = 0;
		active   = 1'b0;
		shift    = 8'h00;
	end
	////////////////////////////////////////////////////////////////
	// Start and stop, seen while the clock line is high
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			bit_cnt = 0;
			active  = 1'b1;
		end
	end
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			active   = 1'b0;
			sda_pull = 1'b0;
		end
	end
	always @(posedge scl) begin
		if (bit_cnt < 8) shift = {shift[6:0], sda};
		else if (rd_mode) begin
			got_ack = sda;
			// Master is done after a refusal, so let go of the bus
			if (sda) active = 1'b0;
		end
		else got_byte = shift;
		bit_cnt = (bit_cnt == 8) ? 0 : bit_cnt + 1;
	end
	// Data only moves while the clock line is low
	always @(negedge scl or rd_mode or rd_byte or clash) begin
		if (scl !== 1'b1) begin
			if (!active) sda_pull = 1'b0;
			else if (rd_mode) sda_pull = (bit_cnt < 8) && !rd_byte[7 - bit_cnt];
			else if (bit_cnt == 8) sda_pull = ack_en;
			else sda_pull = clash;
		end
	end
endmodule

//--- tb/i2cm_engine_tb.sv
`timescale 1ns/1ps
module i2cm_engine_tb;
	logic        clock, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, irq;
	logic        sda_pull, ack_en, rd_mode, clash, got_ack;
	logic [9:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data, rnd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp;
	logic [7:0]  rd_byte, got_byte;
	int          err_total, checks, seed, n;
	int          model [int];

	i2cm_engine i2cm_engine_i (.clock, .sys_rst, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .irq);
	i2cm_slave_model i2cm_slave_model_i (.scl(scl_i), .sda(sda_i), .ack_en, .rd_mode,
		.clash, .rd_byte, .sda_pull, .got_byte, .got_ack);

	// Both lines pulled up; the master may pull either low, the slave only the data line
	assign scl_i = ~scl_oe;
	assign sda_i = ~(sda_oe | sda_pull);
	initial clock = 1'b0;
	always #4 clock = ~clock;
	////////////////////////////////////////////////////////////////
	task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic guard(input int k);
		if (k > 1000) begin
			err_total++;
			$display("CHECK FAILED wait expected answer seen none");
			tally_and_finish;
		end
	endtask
	// bready and rready stay high, so each answer is taken where seen
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		int k;
		s_axi_awaddr  <= {idx, 2'h0};
		s_axi_wdata   <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		for (k = 0; k <= 1000; k++) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		guard(k);
		cmp_val("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		if (er == i2cm_pkg::RESP_OKAY) model[idx] = d;
	endtask
	task automatic axi_rd(input logic [7:0] idx);
		int k;
		s_axi_araddr  <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		for (k = 0; k <= 1000; k++) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				rd_data = s_axi_rdata;
				rd_resp = s_axi_rresp;
				break;
			end
		end
		guard(k);
	endtask
	task automatic chk_rd(input string what, input logic [7:0] idx, input logic [7:0] mask);
		axi_rd(idx);
		cmp_val(what, model[idx] & mask, rd_data & {24'h000000, mask});
		cmp_val("rresp", 0, {30'h0, rd_resp});
	endtask
	// Software waits on transfer-in-progress before the next step
	task automatic run_cmd(input logic [7:0] c);
		int k;
		axi_wr(i2cm_pkg::IDX_COMMAND, c, i2cm_pkg::RESP_OKAY);
		model[i2cm_pkg::IDX_COMMAND] = c & 8'h01;
		axi_rd(i2cm_pkg::IDX_STATUS);
		cmp_val("tip busy", 1, {31'h0, rd_data[i2cm_pkg::STAT_TIP]});
		for (k = 0; k <= 1000; k++) begin
			axi_rd(i2cm_pkg::IDX_STATUS);
			if (rd_data[i2cm_pkg::STAT_TIP] === 1'b0) break;
		end
		guard(k);
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		seed = 95614;
		{err_total, checks} = '0;
		{sys_rst, s_axi_bready, s_axi_rready} = 3'h7;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ack_en, rd_mode, clash} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd_byte} = '0;
		s_axi_wstrb = 4'hF;
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		for (n = 'hE5; n <= 'hEA; n++) model[n] = 0;
		for (n = 'hE5; n <= 'hEA; n++) chk_rd("reset value", n[7:0], 8'hFF);
		axi_wr(8'h10, 8'h5A, i2cm_pkg::RESP_SLVERR);
		axi_rd(8'h10);
		cmp_val("unmapped data", 0, rd_data);
		cmp_val("unmapped resp", {30'h0, i2cm_pkg::RESP_SLVERR}, {30'h0, rd_resp});
		done("reset and map");
		for (n = 'hE5; n <= 'hE7; n++) begin
			rnd = $random(seed);
			axi_wr(n[7:0], rnd[7:0], i2cm_pkg::RESP_OKAY);
			chk_rd("byte register", n[7:0], 8'hFF);
		end
		// Short bit time keeps each byte to a few hundred cycles
		axi_wr(i2cm_pkg::IDX_PRESCALE_HI, 8'h00, i2cm_pkg::RESP_OKAY);
		axi_wr(i2cm_pkg::IDX_PRESCALE_LO, 8'h02 + {6'h0, rnd[9:8]}, i2cm_pkg::RESP_OKAY);
		axi_wr(i2cm_pkg::IDX_COMMAND, 8'h09, i2cm_pkg::RESP_OKAY);
		model[i2cm_pkg::IDX_COMMAND] = 1;
		chk_rd("command readback", i2cm_pkg::IDX_COMMAND, 8'hFF);
		axi_wr(i2cm_pkg::IDX_COMMAND, 8'h00, i2cm_pkg::RESP_OKAY);
		axi_wr(i2cm_pkg::IDX_IRQ_MASK, 8'h00, i2cm_pkg::RESP_OKAY);
		done("registers");
		ack_en <= 1'b1;
		run_cmd(8'h90);
		model[i2cm_pkg::IDX_STATUS] = 8'h40;
		chk_rd("status", i2cm_pkg::IDX_STATUS, 8'hFF);
		cmp_val("slave byte", model[i2cm_pkg::IDX_TRANSMIT], {24'h0, got_byte});
		cmp_val("irq masked", 0, {31'h0, irq});
		model[i2cm_pkg::IDX_IRQ_STATUS] = 1;
		chk_rd("irq status", i2cm_pkg::IDX_IRQ_STATUS, 8'h01);
		axi_wr(i2cm_pkg::IDX_IRQ_MASK, 8'h01, i2cm_pkg::RESP_OKAY);
		repeat (2) @(posedge clock);
		cmp_val("irq raised", 1, {31'h0, irq});
		axi_wr(i2cm_pkg::IDX_IRQ_STATUS, 8'h01, i2cm_pkg::RESP_OKAY);
		repeat (2) @(posedge clock);
		cmp_val("irq cleared", 0, {31'h0, irq});
		done("start and write");
		ack_en <= 1'b0;
		rnd = $random(seed);
		axi_wr(i2cm_pkg::IDX_TRANSMIT, rnd[7:0], i2cm_pkg::RESP_OKAY);
		run_cmd(8'h10);
		model[i2cm_pkg::IDX_STATUS] = 8'hC0;
		chk_rd("status noack", i2cm_pkg::IDX_STATUS, 8'hFF);
		cmp_val("slave byte noack", model[i2cm_pkg::IDX_TRANSMIT], {24'h0, got_byte});
		for (n = 0; n < 2; n++) begin
			rnd = $random(seed);
			rd_mode <= 1'b1;
			rd_byte <= rnd[7:0];
			run_cmd(n ? 8'h28 : 8'h20);
			rd_mode <= 1'b0;
			model[i2cm_pkg::IDX_RECEIVE] = rnd[7:0];
			chk_rd("receive byte", i2cm_pkg::IDX_RECEIVE, 8'hFF);
			cmp_val("master ack", n, {31'h0, got_ack});
		end
		done("reads");
		ack_en <= 1'b1;
		run_cmd(8'h90);
		model[i2cm_pkg::IDX_STATUS] = 8'h40;
		chk_rd("status restart", i2cm_pkg::IDX_STATUS, 8'hC3);
		run_cmd(8'h40);
		model[i2cm_pkg::IDX_STATUS] = 8'h00;
		chk_rd("status stop", i2cm_pkg::IDX_STATUS, 8'h43);
		done("restart and stop");
		clash <= 1'b1;
		rnd = $random(seed);
		axi_wr(i2cm_pkg::IDX_TRANSMIT, rnd[7:0] | 8'h80, i2cm_pkg::RESP_OKAY);
		run_cmd(8'h90);
		model[i2cm_pkg::IDX_STATUS] = 8'h01;
		chk_rd("arb lost", i2cm_pkg::IDX_STATUS, 8'h03);
		model[i2cm_pkg::IDX_IRQ_STATUS] = 2;
		chk_rd("irq arb", i2cm_pkg::IDX_IRQ_STATUS, 8'h02);
		done("arbitration");
		tally_and_finish;
	end
endmodule
